// ===== slp_pkg.sv
// Constants, register map and state encoding for the link power manager
package slp_pkg;
    // Register byte offsets
    localparam logic [7:0]  REG_CTRL_OFS      = 8'h00;
    localparam logic [7:0]  REG_PORT_CFG_OFS  = 8'h04;
    localparam logic [7:0]  REG_EXIT_TMO_OFS  = 8'h08;
    localparam logic [7:0]  REG_STATUS_OFS    = 8'h0C;
    // Control register fields
    localparam int          CTRL_D3_BIT       = 0;
    localparam int          CTRL_LOWPWR_BIT   = 1;
    localparam int          CTRL_AUTOSLP_BIT  = 2;
    localparam int          CTRL_RAID_BIT     = 3;
    localparam int          CTRL_HIE_BIT      = 4;
    localparam logic [31:0] CTRL_RST          = 32'h0000_0000;
    // Port config fields: gate enables at bit 0 up, sleep enables at bit 8 up
    localparam int          CFG_GATE_LSB      = 0;
    localparam int          CFG_SLEEP_LSB     = 8;
    localparam logic [31:0] PORT_CFG_RST      = 32'h0000_0000;
    localparam logic [7:0]  EXIT_TMO_RST      = 8'h00;
    // Status fields: 4 bits per port for state and pin level, then flags
    localparam int          STAT_PORT_W       = 4;
    localparam int          STAT_RAID_BIT     = 16;
    localparam int          STAT_TMO_LSB      = 24;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;
    // Timing, in the units printed, at a 25 ns clock
    localparam int          CLK_PERIOD_PS     = 25000;
    localparam int          PARTIAL_EXIT_NS   = 10;
    localparam int          SLUMBER_EXIT_MS   = 10;
    localparam int          SLEEP_EXIT_MS     = 20;
    localparam int          MS_CYC            = 1000000000 / CLK_PERIOD_PS;
    localparam int          PARTIAL_EXIT_RAW  = (PARTIAL_EXIT_NS * 1000) / CLK_PERIOD_PS;
    localparam int          PARTIAL_EXIT_CYC  = (PARTIAL_EXIT_RAW < 1) ? 1 : PARTIAL_EXIT_RAW;
    localparam int          SLUMBER_EXIT_CYC  = SLUMBER_EXIT_MS * MS_CYC;
    localparam int          SLEEP_EXIT_CYC    = SLEEP_EXIT_MS * MS_CYC;
    // Per-port interface power state
    typedef enum logic [2:0] {
        SLP_ACTIVE  = 3'b000,
        SLP_PARTIAL = 3'b001,
        SLP_SLUMBER = 3'b010,
        SLP_DEVSLP  = 3'b011,
        SLP_WAKING  = 3'b100
    } slp_state_t;
endpackage : slp_pkg

// ===== slp_link_pm.sv
// Link and controller power manager with AXI4-Lite registers
// How it works
// - Accept drive Partial/Slumber requests; never start such a transition ourselves.
// - Acknowledge every power transition request the drive sends (here only requests arriving in Active are acknowledged).
// - Before cable use, wake a Partial or Slumber link with COMWAKE.
// - Partial exit within 10 ns (limit here is one 25 ns cycle), Slumber exit within 10 ms; PHY stays powered (gated in Slumber if gate enabled).
// - PHY is powered down in device sleep.
// - Device sleep exit within 20 ms unless a drive timeout value is set.
// - Device sleep is entered only from Slumber.
// - When enabled, enter and leave device sleep automatically.
// - In D3 only configuration accesses pass; memory and I/O accesses abort.
// - No interrupts in D3; pending status may interrupt after D0 return.
// - In D3 ports show no drive and the PHY is powered down.
// - Returning from D3 to D0 resets nothing.
// - Low power option may ignore drive wakes in Slumber.
// - PHY power gating enabled per port.
// - RAID unavailable when RAID mode and host interface enable bit are set.
// - Sleep pin is open drain: released requests sleep, driven low requests exit.
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module slp_link_pm
    import slp_pkg::*;
#(
    parameter int NPORT            = 2,
    parameter int CNT_W            = 6,
    parameter int SLUMBER_EXIT_LIM = SLUMBER_EXIT_CYC,
    parameter int SLEEP_EXIT_LIM   = SLEEP_EXIT_CYC
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             mem_req,
    output logic                  mem_grant,
    output logic                  mem_abort,
    input  wire logic             irq_pending,
    output logic                  irq_out,
    output logic                  raid_available,
    input  wire logic [NPORT-1:0] drv_pm_req,
    input  wire logic [NPORT-1:0] drv_pm_slumber,
    output logic [NPORT-1:0]      pm_ack,
    input  wire logic [NPORT-1:0] drv_comwake,
    output logic [NPORT-1:0]      comwake_tx,
    input  wire logic [NPORT-1:0] cmd_issue,
    input  wire logic [NPORT-1:0] cmd_done,
    input  wire logic [NPORT-1:0] dev_detect,
    output logic [NPORT-1:0]      port_present,
    output logic [NPORT-1:0]      phy_power_down,
    output logic [NPORT-1:0]      port_phy_power_gate,
    input  wire logic [NPORT-1:0] port_sleep_request_pin_i,
    output logic [NPORT-1:0]      port_sleep_request_pin_o,
    output logic [NPORT-1:0]      port_sleep_request_pin_oe
);
    logic [31:0]      ctrl_ff;
    logic [31:0]      port_cfg_ff;
    logic [7:0]       sleep_exit_timeout_value_ff;
    logic [NPORT-1:0] tmo_flag_ff;
    logic [NPORT-1:0] tmo_evt;
    logic [2:0]       st_ff [NPORT];
    logic [NPORT-1:0] pin_s1_ff;
    logic [NPORT-1:0] pin_s2_ff;
    logic [NPORT-1:0] pin_s3_ff;
    logic [NPORT-1:0] pin_lvl_ff;
    logic             aw_got_ff;
    logic             w_got_ff;
    logic [7:0]       awaddr_ff;
    logic [31:0]      wdata_ff;
    logic [3:0]       wstrb_ff;
    logic             wr_go;
    logic [31:0]      wmask;
    logic [31:0]      status;
    logic [31:0]      exit_sleep_lim;
    logic             in_d3;
    logic             low_pwr;
    logic             auto_sleep;

    assign in_d3      = ctrl_ff[CTRL_D3_BIT];
    assign low_pwr    = ctrl_ff[CTRL_LOWPWR_BIT];
    assign auto_sleep = ctrl_ff[CTRL_AUTOSLP_BIT];
    assign wr_go      = aw_got_ff && w_got_ff && !s_axi_bvalid;
    assign wmask      = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

    // Drive timeout value in milliseconds overrides the default sleep exit limit
    assign exit_sleep_lim = (sleep_exit_timeout_value_ff != EXIT_TMO_RST)
                          ? 32'(sleep_exit_timeout_value_ff * MS_CYC) : 32'(SLEEP_EXIT_LIM);

    // Status image: per-port state, RAID availability, sticky wake timeouts
    always_comb begin
        status = 32'h0000_0000;
        for (int p = 0; p < NPORT; p++) begin
            status[p*STAT_PORT_W +: 3] = st_ff[p];
            status[p*STAT_PORT_W + 3]  = pin_lvl_ff[p];
            status[STAT_TMO_LSB + p]   = tmo_flag_ff[p];
        end
        status[STAT_RAID_BIT] = raid_available;
    end

    // Write address and data are taken independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            awaddr_ff     <= 8'h00;
            wdata_ff      <= 32'h0000_0000;
            wstrb_ff      <= 4'h0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_got_ff && !s_axi_awready) begin
                aw_got_ff     <= 1'b1;
                s_axi_awready <= 1'b1;
                awaddr_ff     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_got_ff && !s_axi_wready) begin
                w_got_ff     <= 1'b1;
                s_axi_wready <= 1'b1;
                wdata_ff     <= s_axi_wdata;
                wstrb_ff     <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
            end
        end
    end

    // Write response; only unmapped offsets answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_ff == REG_CTRL_OFS || awaddr_ff == REG_PORT_CFG_OFS ||
                             awaddr_ff == REG_EXIT_TMO_OFS || awaddr_ff == REG_STATUS_OFS)
                          ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control registers see only aresetn; leaving D3 clears nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff                     <= CTRL_RST;
            port_cfg_ff                 <= PORT_CFG_RST;
            sleep_exit_timeout_value_ff <= EXIT_TMO_RST;
        end else if (wr_go) begin
            if (awaddr_ff == REG_CTRL_OFS)
                ctrl_ff <= (ctrl_ff & ~wmask) | (wdata_ff & wmask);
            if (awaddr_ff == REG_PORT_CFG_OFS)
                port_cfg_ff <= (port_cfg_ff & ~wmask) | (wdata_ff & wmask);
            if (awaddr_ff == REG_EXIT_TMO_OFS && wstrb_ff[0])
                sleep_exit_timeout_value_ff <= wdata_ff[7:0];
        end
    end

    // Sticky timeout flags, write one to clear; a new event wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmo_flag_ff <= '0;
        end else begin
            if (wr_go && awaddr_ff == REG_STATUS_OFS && wstrb_ff[3])
                tmo_flag_ff <= (tmo_flag_ff & ~wdata_ff[STAT_TMO_LSB +: NPORT]) | tmo_evt;
            else
                tmo_flag_ff <= tmo_flag_ff | tmo_evt;
        end
    end

    // Read channel, one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                unique case (s_axi_araddr)
                    REG_CTRL_OFS:     s_axi_rdata <= ctrl_ff;
                    REG_PORT_CFG_OFS: s_axi_rdata <= port_cfg_ff;
                    REG_EXIT_TMO_OFS: s_axi_rdata <= {24'h00_0000, sleep_exit_timeout_value_ff};
                    REG_STATUS_OFS:   s_axi_rdata <= status;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // Controller-level outputs: access gating, interrupt gating, RAID availability
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_grant      <= 1'b0;
            mem_abort      <= 1'b0;
            irq_out        <= 1'b0;
            raid_available <= 1'b0;
        end else begin
            // memory or I/O request in D3 ends in abort
            mem_grant <= mem_req && !in_d3;
            mem_abort <= mem_req && in_d3;
            // interrupt held off in D3, reappears in D0 if still pending
            irq_out <= irq_pending && !in_d3;
            // RAID blocked by host interface enable
            raid_available <= ctrl_ff[CTRL_RAID_BIT] && !ctrl_ff[CTRL_HIE_BIT];
        end
    end

    // Sleep pin sense: three flops, level taken when the last two agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_ff  <= '0;
            pin_s2_ff  <= '0;
            pin_s3_ff  <= '0;
            pin_lvl_ff <= '0;
        end else begin
            pin_s1_ff <= port_sleep_request_pin_i;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            for (int p = 0; p < NPORT; p++)
                if (pin_s2_ff[p] == pin_s3_ff[p])
                    pin_lvl_ff[p] <= pin_s3_ff[p];
        end
    end

    for (genvar g = 0; g < NPORT; g++) begin : g_port
        slp_state_t st;
        logic [CNT_W-1:0] outst_ff;
        logic [31:0]      wait_ff;
        logic             need_cable;
        logic             idle;
        logic             wake_seen;

        assign st         = slp_state_t'(st_ff[g]);
        // cable needed by new or outstanding commands
        assign need_cable = cmd_issue[g] || (outst_ff != '0);
        // idle means nothing outstanding and nothing arriving
        assign idle       = (outst_ff == '0) && !cmd_issue[g];
        // with the low power option a Slumber wake from the drive is missed
        assign wake_seen  = drv_comwake[g] && !(low_pwr && st == SLP_SLUMBER);

        always_ff @(posedge aclk) begin
            if (!aresetn)
                outst_ff <= '0;
            else if (cmd_issue[g] && !cmd_done[g])
                outst_ff <= outst_ff + CNT_W'(1);
            else if (cmd_done[g] && !cmd_issue[g] && outst_ff != '0)
                outst_ff <= outst_ff - CNT_W'(1);
        end

        // Interface power state machine; the host side never starts a Partial or Slumber entry
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                st_ff[g]      <= SLP_ACTIVE;
                wait_ff       <= 32'h0000_0000;
                pm_ack[g]     <= 1'b0;
                comwake_tx[g] <= 1'b0;
                tmo_evt[g]    <= 1'b0;
            end else begin
                pm_ack[g]     <= 1'b0;
                comwake_tx[g] <= 1'b0;
                tmo_evt[g]    <= 1'b0;
                unique case (st)
                    SLP_ACTIVE: begin
                        // only a drive request lowers the link
                        if (drv_pm_req[g]) begin
                            pm_ack[g] <= 1'b1;
                            st_ff[g]  <= drv_pm_slumber[g] ? SLP_SLUMBER : SLP_PARTIAL;
                        end
                    end
                    SLP_PARTIAL, SLP_SLUMBER: begin
                        if (wake_seen) begin
                            st_ff[g] <= SLP_ACTIVE;
                        end else if (need_cable && !in_d3) begin
                            comwake_tx[g] <= 1'b1;
                            st_ff[g]      <= SLP_WAKING;
                            wait_ff <= (st == SLP_PARTIAL) ? 32'(PARTIAL_EXIT_CYC) : 32'(SLUMBER_EXIT_LIM);
                        // sleep only from Slumber, automatic when enabled
                        end else if (st == SLP_SLUMBER && auto_sleep && idle &&
                                     port_cfg_ff[CFG_SLEEP_LSB + g]) begin
                            st_ff[g] <= SLP_DEVSLP;
                        end
                    end
                    SLP_DEVSLP: begin
                        // leave sleep on demand; drive answers with COMWAKE
                        if (need_cable && !in_d3) begin
                            st_ff[g] <= SLP_WAKING;
                            wait_ff  <= exit_sleep_lim;
                        end else if (drv_comwake[g]) begin
                            st_ff[g] <= SLP_ACTIVE;
                        end
                    end
                    SLP_WAKING: begin
                        // link must be back before the limit runs out
                        if (drv_comwake[g]) begin
                            st_ff[g] <= SLP_ACTIVE;
                        end else if (wait_ff <= 32'h0000_0001) begin
                            tmo_evt[g] <= 1'b1;
                            st_ff[g]   <= SLP_ACTIVE;
                        end else begin
                            wait_ff <= wait_ff - 32'h0000_0001;
                        end
                    end
                    default: st_ff[g] <= SLP_ACTIVE;
                endcase
            end
        end

        // Pin and PHY power outputs, all registered
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                port_sleep_request_pin_o[g]  <= 1'b0;
                port_sleep_request_pin_oe[g] <= 1'b1;
                phy_power_down[g]            <= 1'b0;
                port_phy_power_gate[g]       <= 1'b0;
                port_present[g]              <= 1'b0;
            end else begin
                // released in sleep so the drive pull-up raises it, else driven low
                port_sleep_request_pin_o[g]  <= 1'b0;
                port_sleep_request_pin_oe[g] <= !(st == SLP_DEVSLP && !need_cable);
                // PHY off in sleep; and in D3
                phy_power_down[g] <= (st == SLP_DEVSLP) || in_d3;
                // gating only where the port's enable is set
                port_phy_power_gate[g] <= port_cfg_ff[CFG_GATE_LSB + g] &&
                                          (st == SLP_DEVSLP || st == SLP_SLUMBER || in_d3);
                // no drive reported while in D3
                port_present[g] <= dev_detect[g] && !in_d3;
            end
        end
    end
endmodule : slp_link_pm

// ===== slp_link_pm_sva.sv
// Controller- and port-level checker for the link power manager
`timescale 1ns/1ps
module slp_link_pm_chk
    import slp_pkg::*;
#(
    parameter int NPORT = 2
) (
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic             s_axi_bvalid,
    input wire logic             mem_req,
    input wire logic             mem_grant,
    input wire logic             mem_abort,
    input wire logic             irq_pending,
    input wire logic             irq_out,
    input wire logic             raid_available,
    input wire logic [NPORT-1:0] drv_pm_req,
    input wire logic [NPORT-1:0] pm_ack,
    input wire logic [NPORT-1:0] dev_detect,
    input wire logic [NPORT-1:0] port_present,
    input wire logic [NPORT-1:0] phy_power_down,
    input wire logic [NPORT-1:0] port_sleep_request_pin_o
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Acknowledge answers a drive request and lasts one cycle
    sequence s_ack_once;
        $past(drv_pm_req[0]) ##1 !pm_ack[0];
    endsequence
    a_grant_or_abort: assert property (mem_req |=> mem_grant != mem_abort)
        else $error("access neither granted nor aborted");
    a_idle_no_access: assert property (!mem_req |=> !mem_grant && !mem_abort)
        else $error("access outcome without a request");
    a_no_irq_d3: assert property (mem_abort |-> !irq_out)
        else $error("interrupt raised while in D3");
    a_irq_cause: assert property (irq_out |-> $past(irq_pending))
        else $error("interrupt without pending status");
    a_d3_no_drive: assert property (mem_abort |-> port_present == '0 && &phy_power_down)
        else $error("port still shown or powered in D3");
    a_ack_follows: assert property (pm_ack[0] |-> s_ack_once)
        else $error("acknowledge without a drive request");
    a_pin_open_drain: assert property (port_sleep_request_pin_o == '0)
        else $error("sleep pin driven high");
    a_raid_by_write: assert property ($changed(raid_available) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("raid availability changed without a write");
    a_present_cause: assert property (port_present[0] |-> $past(dev_detect[0]))
        else $error("port present without detect");
endmodule : slp_link_pm_chk

bind slp_link_pm slp_link_pm_chk #(.NPORT(NPORT)) u_slp_link_pm_chk (.*);

// ===== slp_drive_model.sv
// Behavioural storage drive on the far side of each link
`timescale 1ns/1ps
module slp_drive_model
#(
    parameter int NPORT = 2
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [NPORT-1:0] want_pm,
    input  wire logic [NPORT-1:0] want_slumber,
    input  wire logic             slow,
    input  wire logic [NPORT-1:0] comwake_tx,
    input  wire logic [NPORT-1:0] port_sleep_request_pin_i,
    output logic [NPORT-1:0]      drv_pm_req,
    output logic [NPORT-1:0]      drv_pm_slumber,
    output logic [NPORT-1:0]      drv_comwake
);
    logic [NPORT-1:0] pin_q_ff;
    int               wake_cnt_ff [NPORT];
    // wake only when the host asks, promptly or slowly
    always_ff @(posedge aclk) begin
        for (int p = 0; p < NPORT; p++) begin
            if (!aresetn) begin
                drv_pm_req[p]     <= 1'h0;
                drv_pm_slumber[p] <= 1'h0;
                drv_comwake[p]    <= 1'h0;
                pin_q_ff[p]       <= 1'h0;
                wake_cnt_ff[p]    <= 0;
            end else begin
                drv_pm_req[p]     <= want_pm[p];
                // Kind line toggles every cycle outside a request
                drv_pm_slumber[p] <= want_pm[p] ? want_slumber[p] : ~drv_pm_slumber[p];
                drv_comwake[p]    <= (wake_cnt_ff[p] == 1);
                pin_q_ff[p]       <= port_sleep_request_pin_i[p];
                if (comwake_tx[p] || (pin_q_ff[p] && !port_sleep_request_pin_i[p]))
                    wake_cnt_ff[p] <= slow ? 40 : 3;
                else if (wake_cnt_ff[p] > 0)
                    wake_cnt_ff[p] <= wake_cnt_ff[p] - 1;
            end
        end
    end
endmodule : slp_drive_model

// ===== slp_link_pm_test.sv
// Self-checking bench for the link power manager
`timescale 1ns/1ps
module slp_link_pm_test import slp_pkg::*;;
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_q;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0, slow = 1'h0, mem_req = 1'h0, irq_pending = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        mem_grant, mem_abort, irq_out, raid_available;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [1:0]  want_pm = 2'h0, want_slumber = 2'h0, cmd_issue = 2'h0, cmd_done = 2'h0, dev_detect = 2'h0;
    logic [1:0]  drv_pm_req, drv_pm_slumber, drv_comwake, pm_ack, comwake_tx, port_present, phy_power_down;
    logic [1:0]  port_phy_power_gate, port_sleep_request_pin_i, port_sleep_request_pin_o, port_sleep_request_pin_oe;
    int          mismatches = 0, tests_run = 0, wake_tx_cnt = 0;

    slp_link_pm #(.SLUMBER_EXIT_LIM(20), .SLEEP_EXIT_LIM(40)) u_slp_link_pm (.*);
    slp_drive_model u_slp_drive_model (.*);

    // Drive's internal pull-up raises a released pin
    assign port_sleep_request_pin_i = (port_sleep_request_pin_o & port_sleep_request_pin_oe) | ~port_sleep_request_pin_oe;
    always #12.5 aclk = ~aclk;
    // Count host wake signals on port 0
    always @(posedge aclk) wake_tx_cnt += int'(comwake_tx[0]);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd_q = s_axi_rdata;
        s_axi_rready <= 1'h0;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rd

    // Poll port 0 state; the bound also caps how long a wake may take
    task automatic st(input logic [2:0] e);
        int n;
        n = 0;
        do begin
            rd(REG_STATUS_OFS, RESP_OKAY);
            n++;
        end while (rd_q[2:0] !== e && n < 20);
        chk({29'h0, rd_q[2:0]}, {29'h0, e});
    endtask : st

    task automatic pm(input logic s);
        @(posedge aclk);
        want_pm      <= 2'h1;
        want_slumber <= {1'h0, s};
        @(posedge aclk);
        want_pm      <= 2'h0;
    endtask : pm

    task automatic cmd(input logic [1:0] i, input logic [1:0] d);
        @(posedge aclk);
        cmd_issue <= i;
        cmd_done  <= d;
        @(posedge aclk);
        cmd_issue <= 2'h0;
        cmd_done  <= 2'h0;
    endtask : cmd

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    // Watchdog: the whole sequence needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        results();
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rd(REG_CTRL_OFS, RESP_OKAY);
        chk(rd_q, CTRL_RST);
        rd(8'h10, RESP_SLVERR);
        chk(rd_q, 32'h0000_0000);
        wr(8'h10, 32'hFFFF_FFFF, RESP_SLVERR);
        $display("register map test done");
        mem_req <= 1'h1;
        irq_pending <= 1'h1;
        dev_detect <= 2'h3;
        wr(REG_PORT_CFG_OFS, 32'h0000_0103, RESP_OKAY);
        chk({31'h0, mem_grant}, 32'h1);
        chk({31'h0, irq_out}, 32'h1);
        wr(REG_CTRL_OFS, 32'h0000_0001, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({30'h0, mem_grant, mem_abort}, 32'h1);
        chk({31'h0, irq_out}, 32'h0);
        chk({28'h0, port_present, phy_power_down}, 32'h3);
        wr(REG_CTRL_OFS, 32'h0000_0000, RESP_OKAY);
        rd(REG_PORT_CFG_OFS, RESP_OKAY);
        chk(rd_q, 32'h0000_0103);
        chk({31'h0, irq_out}, 32'h1);
        mem_req <= 1'h0;
        irq_pending <= 1'h0;
        $display("controller D3 test done");
        wr(REG_CTRL_OFS, 32'h0000_0008, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, raid_available}, 32'h1);
        wr(REG_CTRL_OFS, 32'h0000_0018, RESP_OKAY);
        rd(REG_STATUS_OFS, RESP_OKAY);
        chk({31'h0, rd_q[STAT_RAID_BIT]}, 32'h0);
        wr(REG_CTRL_OFS, 32'h0000_0000, RESP_OKAY);
        $display("raid mode test done");
        pm(1'h1);
        st(3'h2);
        chk({30'h0, port_phy_power_gate}, 32'h1);
        cmd(2'h1, 2'h0);
        st(3'h0);
        chk(wake_tx_cnt, 32'h1);
        cmd(2'h0, 2'h1);
        pm(1'h0);
        st(3'h1);
        cmd(2'h1, 2'h0);
        st(3'h0);
        cmd(2'h0, 2'h1);
        $display("partial and slumber test done");
        wr(REG_CTRL_OFS, 32'h0000_0004, RESP_OKAY);
        pm(1'h0);
        repeat (10) @(posedge aclk);
        st(3'h1);
        cmd(2'h1, 2'h0);
        st(3'h0);
        cmd(2'h0, 2'h1);
        pm(1'h1);
        st(3'h3);
        chk({30'h0, port_sleep_request_pin_oe[0], phy_power_down[0]}, 32'h1);
        cmd(2'h1, 2'h0);
        st(3'h0);
        chk(wake_tx_cnt, 32'h3);
        cmd(2'h0, 2'h1);
        $display("device sleep test done");
        wr(REG_CTRL_OFS, 32'h0000_0002, RESP_OKAY);
        slow <= 1'h1;
        wr(REG_STATUS_OFS, 32'h0100_0000, RESP_OKAY);
        rd(REG_STATUS_OFS, RESP_OKAY);
        chk({31'h0, rd_q[STAT_TMO_LSB]}, 32'h0);
        pm(1'h1);
        st(3'h2);
        cmd(2'h1, 2'h0);
        st(3'h0);
        rd(REG_STATUS_OFS, RESP_OKAY);
        chk({31'h0, rd_q[STAT_TMO_LSB]}, 32'h1);
        cmd(2'h0, 2'h1);
        pm(1'h1);
        repeat (20) @(posedge aclk);
        st(3'h2);
        $display("slow wake test done");
        results();
    end
endmodule : slp_link_pm_test
